// ---- rtl/freq_period_pkg.sv ----
package freq_period_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam real TICK_INTERVAL_US = 0.5;
  localparam int unsigned TICK_CYC = int'(TICK_INTERVAL_US * CLK_HZ / 1_000_000);
  localparam real FILTER_HZ = 10_000.0;
  // Pulse shorter than half the filter period is rejected.
  localparam int unsigned FILT_CYC = int'(CLK_HZ / (2.0 * FILTER_HZ));
  localparam int unsigned GATE_100MS_CYC = CLK_HZ / 10;
  localparam int unsigned GATE_1S_CYC = CLK_HZ;
  localparam int unsigned GATE_10S_CYC = CLK_HZ * 10;

  localparam int RES_W = 24;
  localparam logic [RES_W-1:0] RES_ALL_ONES = 24'hFF_FFFF;

  typedef enum logic [2:0] {
    USE_NORMAL = 3'h0,
    USE_INTERRUPT = 3'h1,
    updown_count_use = 3'h2,
    gated_edge_count_use = 3'h3,
    USE_PERIOD = 3'h4
  } use_e;

  typedef enum logic [1:0] {
    GATE_100MS = 2'h0,
    GATE_1S = 2'h1,
    GATE_10S = 2'h2
  } gate_e;

  typedef struct packed {
    logic [2:0] use_sel;
    logic [1:0] gate_sel;
  } cfg_s;

  typedef struct packed {
    logic             valid;
    logic [RES_W-1:0] value;
  } result_s;

endpackage

// ---- rtl/freq_period_meter.sv ----
`timescale 1ns/1ps
module freq_period_meter
  import freq_period_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        SIG_IN,
  input  wire cfg_s        CFG,
  output result_s          RESULT,
  output logic             UPDATE
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FREQ = 3'b010,
    ST_PER  = 3'b100
  } mode_e;

  function automatic logic [31:0] gate_len(input logic [1:0] g);
    unique case (g)
      GATE_1S:  gate_len = 32'(GATE_1S_CYC);
      GATE_10S: gate_len = 32'(GATE_10S_CYC);
      default:  gate_len = 32'(GATE_100MS_CYC);
    endcase
  endfunction

  // A measurement group stays cleared while its own mode is not running.
  function automatic logic cleared(input logic rst_now, input mode_e cur, input mode_e own);
    cleared = rst_now || (cur != own);
  endfunction

  // Restart and the end strobes are combinational; every output is registered.
  logic        sync1_q;
  logic        sync2_q;
  logic        filt_q, filt_d;
  logic [15:0] fcnt_q, fcnt_d;
  logic        rise;
  mode_e       mode_q, mode_d;
  logic [1:0]  gsel_q, gsel_d;
  logic        restart;
  logic [31:0] gcnt_q, gcnt_d;
  logic [23:0] edges_q, edges_d;
  logic [23:0] edges_now;
  logic        gate_end;
  logic [4:0]  tdiv_q, tdiv_d;
  logic [23:0] ticks_q, ticks_d;
  logic        armed_q, armed_d;
  logic        ovf_q, ovf_d;
  logic        tick;
  logic        per_end;
  logic [23:0] per_val;
  result_s     res_q, res_d;
  logic        upd_q, upd_d;

  // Two flip-flops bring the transducer level into the clock domain.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= SIG_IN;
      sync2_q <= sync1_q;
    end
  end

  // Input level accepted only after it is stable for the filter time.
  always_comb begin
    filt_d = filt_q;
    fcnt_d = '0;
    if (sync2_q != filt_q) begin
      fcnt_d = fcnt_q + 16'h0001;
      if (fcnt_q == 16'(FILT_CYC - 1)) begin
        filt_d = sync2_q;
        fcnt_d = '0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      filt_q <= 1'b0;
      fcnt_q <= '0;
    end else begin
      filt_q <= filt_d;
      fcnt_q <= fcnt_d;
    end
  end

  // A filtered rising edge acts once, in the cycle its level is accepted.
  assign rise = filt_d & ~filt_q;

  // The usage field picks the mode; a new mode, or a new gate in frequency mode, restarts.
  always_comb begin
    unique case (CFG.use_sel)
      gated_edge_count_use: mode_d = ST_FREQ;
      USE_PERIOD:           mode_d = ST_PER;
      default:              mode_d = ST_IDLE;
    endcase
    restart = (mode_d != mode_q) || (mode_q == ST_FREQ && CFG.gate_sel != gsel_q);
    gsel_d  = gsel_q;
    if (restart) gsel_d = CFG.gate_sel;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mode_q <= ST_IDLE;
      gsel_q <= GATE_100MS;
    end else begin
      mode_q <= mode_d;
      gsel_q <= gsel_d;
    end
  end

  // Rising edges are counted over the gate, then counting restarts at once.
  always_comb begin
    gcnt_d    = gcnt_q + 32'h0000_0001;
    edges_now = edges_q;
    gate_end  = 1'b0;
    if (rise && edges_q != RES_ALL_ONES) edges_now = edges_q + 24'h00_0001;
    edges_d   = edges_now;
    if (cleared(restart, mode_q, ST_FREQ)) begin
      gcnt_d  = '0;
      edges_d = '0;
    end else if (gcnt_q == gate_len(gsel_q) - 32'h0000_0001) begin
      gate_end = 1'b1;
      gcnt_d   = '0;
      edges_d  = '0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      gcnt_q  <= '0;
      edges_q <= '0;
    end else begin
      gcnt_q  <= gcnt_d;
      edges_q <= edges_d;
    end
  end

  // Fixed ticks are counted from one rising edge to the next.
  always_comb begin
    tdiv_d  = tdiv_q;
    ticks_d = ticks_q;
    armed_d = armed_q;
    ovf_d   = ovf_q;
    tick    = 1'b0;
    per_end = 1'b0;
    per_val = RES_ALL_ONES;
    if (cleared(restart, mode_q, ST_PER)) begin
      tdiv_d  = '0;
      ticks_d = '0;
      armed_d = 1'b0;
      ovf_d   = 1'b0;
    end else begin
      if (armed_q) begin
        tdiv_d = tdiv_q + 5'h01;
        if (tdiv_q == 5'(TICK_CYC - 1)) begin
          tdiv_d = '0;
          tick   = 1'b1;
        end
      end
      if (tick) begin
        if (ticks_q == RES_ALL_ONES) ovf_d = 1'b1;
        else ticks_d = ticks_q + 24'h00_0001;
      end
      // A period beyond range reads all ones and raises nothing else.
      per_val = ovf_d ? RES_ALL_ONES : ticks_d;
      if (rise) begin
        per_end = armed_q;
        armed_d = 1'b1;
        tdiv_d  = '0;
        ticks_d = '0;
        ovf_d   = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tdiv_q  <= '0;
      ticks_q <= '0;
      armed_q <= 1'b0;
      ovf_q   <= 1'b0;
    end else begin
      tdiv_q  <= tdiv_d;
      ticks_q <= ticks_d;
      armed_q <= armed_d;
      ovf_q   <= ovf_d;
    end
  end

  // The result keeps the last finished measurement; all ones after reset or restart until the first.
  always_comb begin
    res_d = res_q;
    upd_d = 1'b0;
    if (restart) begin
      res_d = '{valid: 1'b0, value: RES_ALL_ONES};
    end else if (gate_end) begin
      res_d = '{valid: 1'b1, value: edges_now};
      upd_d = 1'b1;
    end else if (per_end) begin
      res_d = '{valid: 1'b1, value: per_val};
      upd_d = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      res_q <= '{valid: 1'b0, value: RES_ALL_ONES};
      upd_q <= 1'b0;
    end else begin
      res_q <= res_d;
      upd_q <= upd_d;
    end
  end

  assign RESULT = res_q;
  assign UPDATE = upd_q;

endmodule

// ---- tb/fpm_chk.sv ----
`timescale 1ns/1ps
module fpm_chk
  import freq_period_pkg::*;
(
  input wire logic    CORE_CLK,
  input wire logic    RST,
  input wire cfg_s    CFG,
  input wire result_s RESULT,
  input wire logic    UPDATE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  AST_PULSE: assert property (UPDATE |=> !UPDATE)
    else $error("long update");
  AST_VALID: assert property (UPDATE |-> RESULT.valid)
    else $error("update invalid");
  AST_ONES: assert property (!RESULT.valid |-> RESULT.value == RES_ALL_ONES)
    else $error("idle value");
  AST_FIRST: assert property ($rose(RESULT.valid) |-> UPDATE)
    else $error("silent result");
  AST_HOLD: assert property (!UPDATE && CFG == $past(CFG, 2) |-> $stable(RESULT))
    else $error("result moved");
  AST_IDLE: assert property (
    CFG.use_sel < 3'h3 && $past(CFG.use_sel, 2) < 3'h3 |-> !UPDATE)
    else $error("idle update");
  AST_PMIN: assert property (
    UPDATE && CFG.use_sel == USE_PERIOD && $past(CFG.use_sel, 3) == USE_PERIOD
    |-> RESULT.value > 24'h00_00C6)
    else $error("short period");
  AST_ARM: assert property ($rose(CFG.use_sel == USE_PERIOD) |=> !UPDATE [*8])
    else $error("early period");
  cover property (UPDATE && CFG.use_sel == USE_PERIOD);
  cover property ($rose(RESULT.valid));
  cover property (CFG.use_sel == gated_edge_count_use && !RESULT.valid);
endmodule
bind freq_period_meter fpm_chk chk_i (.CORE_CLK(CORE_CLK), .RST(RST), .CFG(CFG),
  .RESULT(RESULT), .UPDATE(UPDATE));

// ---- tb/pulse_src.sv ----
`timescale 1ns/1ps
module pulse_src (
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic [15:0] half,
  output logic             sig
);
  logic [15:0] cnt = 16'h0000;
  logic        lvl = 1'b0;
  assign sig = lvl;
  // Square wave of half periods of half cycles, resting low while disabled.
  always @(posedge clk) begin
    if (!en || cnt >= half - 16'h0001) begin
      lvl <= en & ~lvl;
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import freq_period_pkg::*;
  logic        CORE_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        en = 1'b0;
  logic [15:0] half = 16'h05DC;
  logic        SIG_IN;
  cfg_s        CFG = 5'h00;
  result_s     RESULT;
  logic        UPDATE;
  int          miscompares = 0;
  int          n_checks = 0;
  freq_period_meter uut (.CORE_CLK(CORE_CLK), .RST(RST), .SIG_IN(SIG_IN), .CFG(CFG),
    .RESULT(RESULT), .UPDATE(UPDATE));
  pulse_src src (.clk(CORE_CLK), .en(en), .half(half), .sig(SIG_IN));
  initial begin
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  task automatic results;
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [24:0] exp, input logic [24:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic setc(input logic [4:0] c, input logic e, input logic [15:0] h);
    @(posedge CORE_CLK);
    CFG <= c;
    en <= e;
    half <= h;
  endtask
  task automatic wait_upd;
    for (int i = 0; i < 12000; i++) begin
      @(negedge CORE_CLK);
      if (UPDATE === 1'b1) return;
    end
    miscompares++;
    $display("wrong value update exp 1 got 0");
    results();
  endtask
  task automatic quiet(input int n);
    logic [24:0] seen = 25'h000_0000;
    repeat (n) begin
      @(negedge CORE_CLK);
      if (UPDATE !== 1'b0) seen = seen + 25'h000_0001;
    end
    chk("updates", 25'h000_0000, seen);
  endtask
  task automatic t_idle;
    for (int u = 0; u < 3; u++) begin
      setc({u[2:0], 2'h0}, 1'b1, 16'h05DC);
      quiet(7000);
      chk("idle", {1'b0, RES_ALL_ONES}, RESULT);
    end
  endtask
  task automatic t_freq;
    for (int g = 0; g < 3; g++) begin
      setc({3'h3, g[1:0]}, 1'b1, 16'h05DC);
      quiet(5000);
      chk("gate", {1'b0, RES_ALL_ONES}, RESULT);
    end
  endtask
  task automatic t_filter;
    setc({3'h4, 2'h0}, 1'b0, 16'h00C8);
    quiet(3000);
    setc({3'h4, 2'h0}, 1'b1, 16'h00C8);
    quiet(8000);
  endtask
  task automatic t_period;
    setc({3'h4, 2'h0}, 1'b1, 16'h05DC);
    wait_upd();
    wait_upd();
    chk("period", {1'b1, 24'h00_012C}, RESULT);
    setc({3'h4, 2'h0}, 1'b1, 16'h09C4);
    wait_upd();
    wait_upd();
    chk("long", {1'b1, 24'h00_01F4}, RESULT);
  endtask
  initial begin
    repeat (4) @(posedge CORE_CLK);
    RST <= 1'b0;
    quiet(2);
    chk("reset", {1'b0, RES_ALL_ONES}, RESULT);
    t_idle();
    t_freq();
    t_filter();
    t_period();
    results();
  end
endmodule
